// *** verilog/trig_gate_pkg.sv ***
/*
 trigger / gate qualifier package: type selector codes, widths, register offsets
 and reset values shared by the qualifier and its helpers.
 assumes nothing beyond a SystemVerilog compiler.
*/
package trig_gate_pkg;

   localparam int unsigned LEVEL_W = 16;
   localparam int unsigned ADDR_W  = 4;
   localparam int unsigned DATA_W  = 32;

   // 4-bit type selector; codes 14 and 15 are unused and mean disabled
   typedef enum logic [3:0]
   {
      hyst_gate_open_high = 4'h0,
      hyst_gate_open_low  = 4'h1,
      above_gate          = 4'h2,
      below_gate          = 4'h3,
      cross_up_start      = 4'h4,
      cross_down_start    = 4'h5,
      in_window_gate      = 4'h6,
      out_window_gate     = 4'h7,
      logic_one_gate      = 4'h8,
      logic_zero_gate     = 4'h9,
      logic_one_start     = 4'ha,
      logic_zero_start    = 4'hb,
      rising_edge_start   = 4'hc,
      falling_edge_start  = 4'hd
   } trig_type_t;

   localparam logic [3:0] TYPE_DISABLED = 4'hf;

   // register offsets (byte addresses of word registers)
   localparam logic [ADDR_W-1:0] REG_TYPE   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_LOWER  = 4'h4;
   localparam logic [ADDR_W-1:0] REG_UPPER  = 4'h8;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;

   // reset values
   localparam logic [3:0]         TYPE_RESET  = TYPE_DISABLED;
   localparam logic [LEVEL_W-1:0] LOWER_RESET = 16'h0000;
   localparam logic [LEVEL_W-1:0] UPPER_RESET = 16'hffff;

   // status register bit positions
   localparam int unsigned STAT_ENABLE_BIT = 0;
   localparam int unsigned STAT_LATCH_BIT  = 1;
   localparam int unsigned STAT_DIG_BIT    = 2;

endpackage

// *** verilog/level_sync.sv ***
/*
 two-flip-flop synchroniser for one asynchronous level.
 assumes an active-low asynchronous reset already released synchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module level_sync
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // level
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta;

   // first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

`default_nettype wire

// *** verilog/level_compare.sv ***
/*
 strict comparison of the analog trigger level against both limits.
 assumes level and limits are unsigned counts, zero being negative full scale.
*/
`timescale 1ns/1ps
`default_nettype none

module level_compare
#(
   parameter int unsigned WIDTH = 16
)
(
   // operands
   input  wire logic [WIDTH-1:0] level,
   input  wire logic [WIDTH-1:0] lower_limit_counts,
   input  wire logic [WIDTH-1:0] upper_limit_counts,
   // results
   output logic                  above_upper,
   output logic                  below_lower,
   output logic                  in_window
);
   assign above_upper = level > upper_limit_counts;
   assign below_lower = level < lower_limit_counts;
   assign in_window   = (level > lower_limit_counts) && (level < upper_limit_counts);
endmodule

`default_nettype wire

// *** verilog/trig_gate_qualifier.sv ***
/*
 conversion-enable qualifier for fourteen analog and digital trigger / gate types,
 with a small register port for type, limits and status.
 assumes the analog level arrives already digitised on this clock; the digital
 trigger pin is asynchronous. limits are not checked for order: with lower above
 upper the inside-window type never opens and the outside-window type is always open.
 rdata reads zero except in the cycle after a read strobe.
*/
// Design decisions made here: the address map and strobed register access.
// Functional notes
// - hysteresis: on above upper, off below lower
// - hysteresis: on below lower, off above upper
// - enable exactly while level above upper
// - enable exactly while level below lower
// - rising crossing of upper sets enable
// - falling crossing of lower sets enable
// - trigger types latch enable, ignore input
// - enable while level inside window
// - enable while level outside window
// - enable while digital input is one
// - enable while digital input is zero
// - digital one found sets latched enable
// - digital zero found sets latched enable
// - digital rising edge sets latched enable
// - digital falling edge sets latched enable
// - digital types ignore thresholds
`timescale 1ns/1ps
`default_nettype none

module trig_gate_qualifier
#(
   parameter int unsigned WIDTH = trig_gate_pkg::LEVEL_W
)
(
   // clock and reset
   input  wire logic                             clock,
   input  wire logic                             nrst,
   // register port
   input  wire logic [trig_gate_pkg::ADDR_W-1:0] addr,
   input  wire logic [trig_gate_pkg::DATA_W-1:0] wdata,
   input  wire logic                             wr,
   input  wire logic                             rd,
   output logic      [trig_gate_pkg::DATA_W-1:0] rdata,
   // trigger inputs
   input  wire logic [WIDTH-1:0]                 analog_level,
   input  wire logic                             digital_trig,
   // result
   output logic                                  conv_enable
);
   import trig_gate_pkg::*;

   // reset constants are LEVEL_W wide, so wider levels are refused
   if (WIDTH < 1 || WIDTH > LEVEL_W)
   begin : g_width_check
      $error("WIDTH out of range");
   end

   // internal reset, configuration and decode state
   logic             rst_meta;
   logic             rst_n;
   logic [3:0]       type_sel;
   logic [WIDTH-1:0] lower_limit_counts;
   logic [WIDTH-1:0] upper_limit_counts;
   logic             reconfig;
   logic             dig;
   logic             dig_prev;
   logic             above_upper;
   logic             below_lower;
   logic             in_window;
   logic             above_prev;
   logic             below_prev;
   logic             history_ok;
   logic             latched;
   logic             hyst_state;
   logic             next_hyst_state;
   logic             gate_level;
   logic             start_hit;
   logic             next_enable;

   // reset release through two flops
   // assertion acts at once; release waits two edges to avoid a ragged start
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // start types latch; gate types follow their condition
   function automatic logic is_start_type(input logic [3:0] t);
      is_start_type = (t == cross_up_start) || (t == cross_down_start) ||
                      (t == logic_one_start) || (t == logic_zero_start) ||
                      (t == rising_edge_start) || (t == falling_edge_start);
   endfunction

   function automatic logic is_digital_type(input logic [3:0] t);
      is_digital_type = (t >= logic_one_gate) && (t <= falling_edge_start);
   endfunction

   // register writes; any write to a config register restarts qualification
   // status is read-only; writes to it or to unmapped offsets are dropped
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         type_sel           <= TYPE_RESET;
         lower_limit_counts <= LOWER_RESET[WIDTH-1:0];
         upper_limit_counts <= UPPER_RESET[WIDTH-1:0];
         reconfig           <= 1'b1;
      end
      else
      begin
         reconfig <= 1'b0;
         if (wr)
         begin
            if (addr == REG_TYPE)
            begin
               type_sel <= wdata[3:0];
               reconfig <= 1'b1;
            end
            else if (addr == REG_LOWER)
            begin
               lower_limit_counts <= wdata[WIDTH-1:0];
               reconfig           <= 1'b1;
            end
            else if (addr == REG_UPPER)
            begin
               upper_limit_counts <= wdata[WIDTH-1:0];
               reconfig           <= 1'b1;
            end
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   // the digital-type flag tells software which input the type uses
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= '0;
      else if (rd)
      begin
         if (addr == REG_TYPE)
            rdata <= {28'h0000000, type_sel};
         else if (addr == REG_LOWER)
            rdata <= DATA_W'(lower_limit_counts);
         else if (addr == REG_UPPER)
            rdata <= DATA_W'(upper_limit_counts);
         else if (addr == REG_STATUS)
            rdata <= {29'h00000000, is_digital_type(type_sel), latched, conv_enable};
         else
            rdata <= '0;
      end
      else
         rdata <= '0;
   end

   // only the second stage of the pin synchroniser is read
   level_sync u_dig_sync
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (digital_trig),
      .sync_out (dig)
   );

   // strict compares: a level equal to a limit is on neither side
   level_compare #(.WIDTH(WIDTH)) u_cmp
   (
      .level              (analog_level),
      .lower_limit_counts (lower_limit_counts),
      .upper_limit_counts (upper_limit_counts),
      .above_upper        (above_upper),
      .below_lower        (below_lower),
      .in_window          (in_window)
   );

   // previous pin sample for the edge types
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         dig_prev <= 1'b0;
      else
         dig_prev <= dig;
   end

   // previous-sample history for crossings and edges; invalid after reconfig
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         above_prev <= 1'b0;
         below_prev <= 1'b0;
         history_ok <= 1'b0;
      end
      else
      begin
         above_prev <= above_upper;
         below_prev <= below_lower;
         history_ok <= !reconfig;
      end
   end

   // hysteresis state and level gates
   // once either hysteresis type is past its reconfig cycle, conv_enable always equals hyst_state
   always_comb
   begin
      next_hyst_state = hyst_state;
      gate_level      = 1'b0;
      start_hit       = 1'b0;
      case (type_sel)
         hyst_gate_open_high:
         begin
            if (above_upper)
               next_hyst_state = 1'b1;
            else if (below_lower)
               next_hyst_state = 1'b0;
         end
         hyst_gate_open_low:
         begin
            if (below_lower)
               next_hyst_state = 1'b1;
            else if (above_upper)
               next_hyst_state = 1'b0;
         end
         above_gate:      gate_level = above_upper;
         below_gate:      gate_level = below_lower;
         in_window_gate:  gate_level = in_window;
         out_window_gate: gate_level = above_upper || below_lower;
         // digital types read only the synchronised pin, never the limits
         logic_one_gate:     gate_level = dig;
         logic_zero_gate:    gate_level = !dig;
         cross_up_start:     start_hit = history_ok && !above_prev && above_upper;
         cross_down_start:   start_hit = history_ok && !below_prev && below_lower;
         logic_one_start:    start_hit = dig;
         logic_zero_start:   start_hit = !dig;
         rising_edge_start:  start_hit = history_ok && !dig_prev && dig;
         falling_edge_start: start_hit = history_ok && dig_prev && !dig;
         default:
         begin
            // codes e and f: disabled, nothing is held
            next_hyst_state = 1'b0;
         end
      endcase
   end

   // crossings need a valid previous sample, so a level already past the limit
   // at configuration time does not fire until it returns and crosses again
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hyst_state <= 1'b0;
         latched    <= 1'b0;
      end
      else if (reconfig)
      begin
         hyst_state <= 1'b0;
         latched    <= 1'b0;
      end
      else
      begin
         hyst_state <= next_hyst_state;
         if (is_start_type(type_sel) && start_hit)
            latched <= 1'b1;
      end
   end

   // reconfig wins over every type, so a stale latch never leaks out
   always_comb
   begin
      next_enable = 1'b0;
      if (reconfig)
         next_enable = 1'b0;
      else if (is_start_type(type_sel))
         next_enable = latched || start_hit;
      else if (type_sel == hyst_gate_open_high || type_sel == hyst_gate_open_low)
         next_enable = next_hyst_state;
      else
         next_enable = gate_level;
   end

   // registered so a limit compare cannot glitch the enable
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         conv_enable <= 1'b0;
      else
         conv_enable <= next_enable;
   end

endmodule

`default_nettype wire

// *** tb/trig_source_model.sv ***
/*
 external trigger source: an analog level in counts and a logic pin.
 assumes the bench commands each new value; it shows one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_source_model
#(
   parameter int unsigned WIDTH = 16
)
(
   // clock and commands
   input  wire logic             clock,
   input  wire logic [WIDTH-1:0] level_cmd,
   input  wire logic             pin_cmd,
   // trigger lines
   output logic      [WIDTH-1:0] analog_level,
   output logic                  digital_trig
);
   initial
   begin
      analog_level = '0;
      digital_trig = 1'b0;
   end
   // changes just after an edge, like a source on this clock
   always @(posedge clock)
   begin
      analog_level <= level_cmd;
      digital_trig <= pin_cmd;
   end
endmodule
`default_nettype wire

// *** tb/trig_gate_qualifier_asserts.sv ***
/*
 port checker for the trigger / gate qualifier, bound to its top module.
 assumes writes land at the strobe edge and enable lags level by one edge.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_gate_qualifier_chk
#(
   parameter int unsigned WIDTH = 16
)
(
   // clock, reset, register port
   input wire logic                             clock,
   input wire logic                             nrst,
   input wire logic [trig_gate_pkg::ADDR_W-1:0] addr,
   input wire logic [trig_gate_pkg::DATA_W-1:0] wdata,
   input wire logic                             wr,
   input wire logic                             rd,
   input wire logic [trig_gate_pkg::DATA_W-1:0] rdata,
   // trigger lines and result
   input wire logic [WIDTH-1:0]                 analog_level,
   input wire logic                             digital_trig,
   input wire logic                             conv_enable
);
   import trig_gate_pkg::*;
   logic [3:0]       typ;
   logic [WIDTH-1:0] lo;
   logic [WIDTH-1:0] hi;
   logic [2:0]       quiet;
   logic             cfg_wr;
   logic             live;
   assign cfg_wr = wr && (addr == REG_TYPE || addr == REG_LOWER || addr == REG_UPPER);
   // settle margin covers sync flops and the reconfig cycle
   assign live = quiet == 3'h7;
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         quiet <= 3'h0;
      else if (cfg_wr)
         quiet <= 3'h0;
      else if (!live)
         quiet <= quiet + 3'h1;
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         typ <= TYPE_RESET;
         lo <= WIDTH'(LOWER_RESET);
         hi <= WIDTH'(UPPER_RESET);
      end
      else if (wr)
      begin
         if (addr == REG_TYPE)
            typ <= wdata[3:0];
         if (addr == REG_LOWER)
            lo <= wdata[WIDTH-1:0];
         if (addr == REG_UPPER)
            hi <= wdata[WIDTH-1:0];
      end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_live(logic [3:0] t);
      live && typ == t;
   endsequence
   property p_above;
      s_live(above_gate) |-> conv_enable == ($past(analog_level) > hi);
   endproperty
   property p_below;
      s_live(below_gate) |-> conv_enable == ($past(analog_level) < lo);
   endproperty
   property p_inwin;
      s_live(in_window_gate) |-> conv_enable == ($past(analog_level) > lo && $past(analog_level) < hi);
   endproperty
   property p_outwin;
      s_live(out_window_gate) |-> conv_enable == ($past(analog_level) < lo || $past(analog_level) > hi);
   endproperty
   property p_hyst_high;
      s_live(hyst_gate_open_high) |-> conv_enable == ($past(analog_level) > hi ? 1'b1 :
         ($past(analog_level) < lo ? 1'b0 : $past(conv_enable)));
   endproperty
   property p_hyst_low;
      s_live(hyst_gate_open_low) |-> conv_enable == ($past(analog_level) < lo ? 1'b1 :
         ($past(analog_level) > hi ? 1'b0 : $past(conv_enable)));
   endproperty
   property p_dig_one;
      s_live(logic_one_gate) |-> conv_enable == $past(digital_trig, 3);
   endproperty
   property p_dig_zero;
      s_live(logic_zero_gate) |-> conv_enable == !$past(digital_trig, 3);
   endproperty
   property p_latch;
      live && typ inside {4'h4, 4'h5, 4'ha, 4'hb, 4'hc, 4'hd} && $past(conv_enable) |-> conv_enable;
   endproperty
   property p_cfg_clear;
      cfg_wr |-> ##2 !conv_enable;
   endproperty
   property p_unused;
      live && typ > 4'hd |-> !conv_enable;
   endproperty
   property p_read_type;
      rd && addr == REG_TYPE |=> rdata == {28'h0000000, typ};
   endproperty
   a_above: assert property (p_above) else $error("above gate enable wrong");
   a_below: assert property (p_below) else $error("below gate enable wrong");
   a_inwin: assert property (p_inwin) else $error("inside window enable wrong");
   a_outwin: assert property (p_outwin) else $error("outside window enable wrong");
   a_hyst_high: assert property (p_hyst_high) else $error("hysteresis high enable wrong");
   a_hyst_low: assert property (p_hyst_low) else $error("hysteresis low enable wrong");
   a_dig_one: assert property (p_dig_one) else $error("logic one gate wrong");
   a_dig_zero: assert property (p_dig_zero) else $error("logic zero gate wrong");
   a_latch: assert property (p_latch) else $error("start type dropped enable");
   a_cfg_clear: assert property (p_cfg_clear) else $error("enable not cleared by write");
   a_unused: assert property (p_unused) else $error("unused code enabled");
   a_read_type: assert property (p_read_type) else $error("type readback wrong");
endmodule
bind trig_gate_qualifier trig_gate_qualifier_chk #(.WIDTH(WIDTH)) u_chk
(
   .clock(clock),
   .nrst(nrst),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .analog_level(analog_level),
   .digital_trig(digital_trig),
   .conv_enable(conv_enable)
);
`default_nettype wire

// *** tb/trig_gate_qualifier_tb_top.sv ***
/*
 self-checking bench for the trigger / gate qualifier.
 assumes the checker is bound and the source model drives the trigger lines.
*/
`timescale 1ns/1ps
`default_nettype none
module trig_gate_qualifier_tb_top;
   import trig_gate_pkg::*;
   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [15:0]       level_cmd = 16'h0;
   logic              pin_cmd = 1'b0;
   logic [15:0]       analog_level;
   logic              digital_trig;
   logic              conv_enable;
   logic [3:0]        cur = 4'hf;
   int                failures = 0;
   int                n_compared = 0;
   always #5 clock = ~clock;
   trig_gate_qualifier #(.WIDTH(16)) dut
      (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
       .analog_level(analog_level), .digital_trig(digital_trig), .conv_enable(conv_enable));
   trig_source_model #(.WIDTH(16)) src
      (.clock(clock), .level_cmd(level_cmd), .pin_cmd(pin_cmd),
       .analog_level(analog_level), .digital_trig(digital_trig));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 check(what, rdata, exp);
   endtask
   // a type write only when the type changes; the wait covers sync and reconfig
   task automatic step(input logic [3:0] t, input int lvl, input int pin, input int exp);
      if (t !== cur)
      begin
         wreg(REG_TYPE, {28'h0, t});
         cur = t;
         repeat (2) @(posedge clock);
      end
      @(posedge clock);
      level_cmd <= 16'(lvl);
      pin_cmd <= pin[0];
      repeat (6) @(posedge clock);
      #1 check("conv_enable", {31'h0, conv_enable}, 32'(exp));
   endtask
   task automatic t_regs;
      rreg(REG_TYPE, 32'hf, "type");
      rreg(REG_LOWER, 32'h0, "lower");
      rreg(REG_UPPER, 32'hffff, "upper");
      rreg(4'h2, 32'h0, "unmapped");
      wreg(REG_LOWER, 32'hffff0064);
      wreg(REG_UPPER, 32'h000000c8);
      rreg(REG_LOWER, 32'h64, "lower");
      step(4'he, 250, 1, 0);
   endtask
   task automatic t_gates;
      step(4'h2, 200, 0, 0);
      step(4'h2, 201, 0, 1);
      rreg(REG_STATUS, 32'h1, "status");
      step(4'h3, 100, 0, 0);
      step(4'h3, 99, 0, 1);
      step(4'h6, 100, 0, 0);
      step(4'h6, 150, 0, 1);
      step(4'h6, 200, 0, 0);
      step(4'h7, 150, 0, 0);
      step(4'h7, 250, 0, 1);
      step(4'h7, 50, 0, 1);
   endtask
   task automatic t_hyst;
      step(4'h0, 150, 0, 0);
      step(4'h0, 250, 0, 1);
      step(4'h0, 150, 0, 1);
      step(4'h0, 50, 0, 0);
      step(4'h1, 250, 0, 0);
      step(4'h1, 150, 0, 0);
      step(4'h1, 50, 0, 1);
      step(4'h1, 150, 0, 1);
      step(4'h1, 250, 0, 0);
   endtask
   task automatic t_cross;
      step(4'h4, 150, 0, 0);
      step(4'h4, 250, 0, 1);
      step(4'h4, 50, 0, 1);
      wreg(REG_UPPER, 32'h000000c8);
      @(posedge clock);
      #1 check("cleared", {31'h0, conv_enable}, 32'h0);
      step(4'h4, 250, 0, 1);
      step(4'h5, 150, 0, 0);
      step(4'h5, 50, 0, 1);
      step(4'h5, 250, 0, 1);
   endtask
   task automatic t_digital;
      step(4'h8, 50, 1, 1);
      step(4'h8, 250, 0, 0);
      step(4'h9, 50, 1, 0);
      step(4'h9, 150, 0, 1);
      step(4'ha, 250, 0, 0);
      step(4'ha, 250, 1, 1);
      step(4'hb, 150, 0, 1);
      step(4'hb, 150, 1, 1);
      step(4'hc, 150, 1, 0);
      step(4'hc, 150, 0, 0);
      step(4'hc, 150, 1, 1);
      step(4'hd, 150, 1, 0);
      step(4'hd, 150, 0, 1);
      step(4'hd, 150, 1, 1);
      step(4'hd, 50, 0, 1);
      rreg(REG_STATUS, 32'h7, "status");
   endtask
   // mid-run reset while a start type holds its latch
   task automatic t_reset;
      @(posedge clock);
      nrst <= 1'b0;
      @(posedge clock);
      #1 check("reset enable", {31'h0, conv_enable}, 32'h0);
      @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      cur = 4'hf;
      rreg(REG_TYPE, 32'hf, "type after reset");
      rreg(REG_UPPER, 32'hffff, "upper after reset");
   endtask
   task automatic report_and_stop;
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      t_regs();
      t_gates();
      t_hyst();
      t_cross();
      t_digital();
      t_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
